// ==== spfs_top.v ====
// Shared pin function select: picks peripheral or port per pin.
// Assumes all inputs synchronous to clock_i; the pad logic resolves
// each pin from its output and output enable.
`timescale 1ns/100ps
`include "spfs_defs.vh"

module spfs_top #(
  parameter PORT_W = 8
)
(
  input wire clock_i,
  input wire rst_i,
  // Port B/E/F general port side
  input wire [PORT_W-1:0] port_b_out_i,
  input wire [PORT_W-1:0] port_b_dir_i,
  input wire [PORT_W-1:0] port_e_out_i,
  input wire [PORT_W-1:0] port_e_dir_i,
  input wire [PORT_W-1:0] port_f_out_i,
  input wire [PORT_W-1:0] port_f_dir_i,
  output reg [PORT_W-1:0] port_b_in_o,
  output reg [PORT_W-1:0] port_e_in_o,
  output reg [PORT_W-1:0] port_f_in_o,
  // Pins: input level, output level, output enable
  input wire [PORT_W-1:0] pin_b_i,
  input wire [PORT_W-1:0] pin_e_i,
  input wire [PORT_W-1:0] pin_f_i,
  output reg [PORT_W-1:0] pin_b_o,
  output reg [PORT_W-1:0] pin_e_o,
  output reg [PORT_W-1:0] pin_f_o,
  output reg [PORT_W-1:0] pin_b_oe_o,
  output reg [PORT_W-1:0] pin_e_oe_o,
  output reg [PORT_W-1:0] pin_f_oe_o,
  // DRAM controller side, index 0 bank a, 1 bank b
  input wire [1:0] dram_pins_en_i,
  input wire dram_bus16_i,
  input wire dram_one_col_i,
  input wire dram_addr0_i,
  input wire [1:0] dram_row_n_i,
  input wire [1:0] dram_col_n_i,
  input wire [1:0] dram_write_n_i,
  // DMA channels a..c
  input wire [2:0] dma_ext_sel_i,
  input wire [2:0] dma_ack_en_i,
  input wire [2:0] dma_ack_i,
  output reg [2:0] dma_request_o,
  // Serial channels a..c
  input wire [2:0] ser_clk_oe_i,
  input wire [2:0] ser_clk_i,
  input wire [2:0] ser_tx_en_i,
  input wire [2:0] ser_tx_i,
  output reg [2:0] ser_clk_o,
  output reg [2:0] ser_rx_o,
  // PWM channels a..d
  input wire [3:0] pwm_out_en_i,
  input wire [3:0] pwm_wave_i,
  output reg [3:0] pwm_trigger_o,
  // External interrupts a..d
  input wire [3:0] irq_en_i,
  output reg [3:0] ext_irq_o,
  // Converter trigger and analog input selection
  input wire adc_ext_trig_sel_i,
  output reg converter_trigger_o,
  input wire [3:0] analog_input_control_i,
  output reg [3:0] analog_inputs_en_o
);

  // ==========================================================
  // Declarations
  wire [1:0] route_row_n; // Routed row strobes
  wire [1:0] route_col_low_n; // Routed even/shared column strobes
  wire [1:0] route_col_high_n; // Routed odd column or write
  wire [1:0] route_write_n; // Routed write strobes
  reg [PORT_W-1:0] b_en; // Peripheral claims port B pin
  reg [PORT_W-1:0] b_val; // Peripheral level on port B pin
  reg [PORT_W-1:0] e_en; // Peripheral claims port E pin
  reg [PORT_W-1:0] e_val; // Peripheral level on port E pin
  reg [PORT_W-1:0] f_en; // Peripheral claims port F pin
  reg [PORT_W-1:0] f_val; // Peripheral level on port F pin
  wire [3*PORT_W-1:0] all_en; // Claims of all three ports
  wire [3*PORT_W-1:0] all_val; // Peripheral levels, all ports
  wire [3*PORT_W-1:0] all_port; // Port output levels
  wire [3*PORT_W-1:0] all_dir; // Port output directions
  wire [3*PORT_W-1:0] next_out; // Next pin output levels
  wire [3*PORT_W-1:0] next_oe; // Next pin output enables
  wire [2:0] next_dma_request; // Gated DMA request inputs
  wire [2:0] next_ser_clk; // Serial clock inputs
  wire [3:0] next_pwm_trigger; // PWM trigger inputs, b and d gated
  wire [3:0] next_ext_irq; // Gated interrupt inputs
  wire next_converter_trigger; // Gated converter trigger
  genvar g;

  // ==========================================================
  // DRAM strobe routing, one router per bank
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : bank
      spfs_dram_route u_route
      (
        .bus16_i(dram_bus16_i),
        .one_col_i(dram_one_col_i),
        .addr0_i(dram_addr0_i),
        .row_n_i(dram_row_n_i[g]),
        .col_n_i(dram_col_n_i[g]),
        .write_n_i(dram_write_n_i[g]),
        .row_n_o(route_row_n[g]),
        .col_low_n_o(route_col_low_n[g]),
        .col_high_n_o(route_col_high_n[g]),
        .write_n_o(route_write_n[g])
      );
    end
  endgenerate

  // ==========================================================
  // Peripheral claims per pin
  // Which peripheral drives each pin, and with what level
  always @*
  begin
    b_en = `SPFS_RST_PORT;
    b_val = `SPFS_RST_PORT;
    e_en = `SPFS_RST_PORT;
    e_val = `SPFS_RST_PORT;
    f_en = `SPFS_RST_PORT;
    f_val = `SPFS_RST_PORT;
    // DRAM bank a pins
    b_en[`SPFS_PB_ROW_A] = dram_pins_en_i[0];
    b_val[`SPFS_PB_ROW_A] = route_row_n[0];
    b_en[`SPFS_PB_COL_LOW_A] = dram_pins_en_i[0];
    b_val[`SPFS_PB_COL_LOW_A] = route_col_low_n[0];
    b_en[`SPFS_PB_COL_HIGH_A] = dram_pins_en_i[0];
    b_val[`SPFS_PB_COL_HIGH_A] = route_col_high_n[0];
    b_en[`SPFS_PB_WRITE_A] = dram_pins_en_i[0];
    b_val[`SPFS_PB_WRITE_A] = route_write_n[0];
    // DRAM bank b pins
    b_en[`SPFS_PB_ROW_B] = dram_pins_en_i[1];
    b_val[`SPFS_PB_ROW_B] = route_row_n[1];
    b_en[`SPFS_PB_COL_LOW_B] = dram_pins_en_i[1];
    b_val[`SPFS_PB_COL_LOW_B] = route_col_low_n[1];
    b_en[`SPFS_PB_WRITE_B] = dram_pins_en_i[1];
    b_val[`SPFS_PB_WRITE_B] = route_write_n[1];
    // Bank b high strobe, else DMA acknowledge c when enabled
    if (dram_pins_en_i[1])
    begin
      b_en[`SPFS_PB_COL_HIGH_B] = 1'b1;
      b_val[`SPFS_PB_COL_HIGH_B] = route_col_high_n[1];
    end
    else
    begin
      b_en[`SPFS_PB_COL_HIGH_B] = dma_ack_en_i[2];
      b_val[`SPFS_PB_COL_HIGH_B] = dma_ack_i[2];
    end
    // DMA acknowledge a and b
    e_en[`SPFS_PE_DACK_A] = dma_ack_en_i[0];
    e_val[`SPFS_PE_DACK_A] = dma_ack_i[0];
    e_en[`SPFS_PE_DACK_B] = dma_ack_en_i[1];
    e_val[`SPFS_PE_DACK_B] = dma_ack_i[1];
    // Serial clocks b and c share interrupt pins c and d
    e_en[`SPFS_PE_IRQ_C] = ser_clk_oe_i[1];
    e_val[`SPFS_PE_IRQ_C] = ser_clk_i[1];
    e_en[`SPFS_PE_IRQ_D] = ser_clk_oe_i[2];
    e_val[`SPFS_PE_IRQ_D] = ser_clk_i[2];
    // Serial transmit pins
    f_en[`SPFS_PF_TX_A] = ser_tx_en_i[0];
    f_val[`SPFS_PF_TX_A] = ser_tx_i[0];
    f_en[`SPFS_PF_TX_B] = ser_tx_en_i[1];
    f_val[`SPFS_PF_TX_B] = ser_tx_i[1];
    // Serial c transmit wins over PWM wave c
    if (ser_tx_en_i[2])
    begin
      f_en[`SPFS_PF_TX_C] = 1'b1;
      f_val[`SPFS_PF_TX_C] = ser_tx_i[2];
    end
    else
    begin
      f_en[`SPFS_PF_TX_C] = pwm_out_en_i[2];
      f_val[`SPFS_PF_TX_C] = pwm_wave_i[2];
    end
    // Serial a clock wins over PWM wave d
    if (ser_clk_oe_i[0])
    begin
      f_en[`SPFS_PF_SCLK_A] = 1'b1;
      f_val[`SPFS_PF_SCLK_A] = ser_clk_i[0];
    end
    else
    begin
      f_en[`SPFS_PF_SCLK_A] = pwm_out_en_i[3];
      f_val[`SPFS_PF_SCLK_A] = pwm_wave_i[3];
    end
    // PWM waves a and b
    f_en[`SPFS_PF_WAVE_A] = pwm_out_en_i[0];
    f_val[`SPFS_PF_WAVE_A] = pwm_wave_i[0];
    f_en[`SPFS_PF_RX_C] = pwm_out_en_i[1];
    f_val[`SPFS_PF_RX_C] = pwm_wave_i[1];
  end

  // ==========================================================
  // Per-pin output selection over all 24 pins
  assign all_en = {f_en, e_en, b_en};
  assign all_val = {f_val, e_val, b_val};
  assign all_port = {port_f_out_i, port_e_out_i, port_b_out_i};
  assign all_dir = {port_f_dir_i, port_e_dir_i, port_b_dir_i};

  generate
    for (g = 0; g < 3*PORT_W; g = g + 1)
    begin : pin
      // Peripheral level overrides the port level
      assign next_out[g] = all_en[g] ? all_val[g] : all_port[g];
      assign next_oe[g] = all_en[g] | all_dir[g];
    end
  endgenerate

  // ==========================================================
  // Input function gating
  assign next_dma_request[0] = pin_e_i[`SPFS_PE_DREQ_A] & dma_ext_sel_i[0];
  assign next_dma_request[1] = pin_e_i[`SPFS_PE_DREQ_B] & dma_ext_sel_i[1];
  // Request c shares bank b low strobe pin
  assign next_dma_request[2] = pin_b_i[`SPFS_PB_COL_LOW_B] &
    dma_ext_sel_i[2];
  // Input clocks only when the channel drives none
  assign next_ser_clk[0] = pin_f_i[`SPFS_PF_SCLK_A] & ~ser_clk_oe_i[0];
  assign next_ser_clk[1] = pin_e_i[`SPFS_PE_IRQ_C] & ~ser_clk_oe_i[1];
  assign next_ser_clk[2] = pin_e_i[`SPFS_PE_IRQ_D] & ~ser_clk_oe_i[2];
  // Triggers b and d only while the shared transmitter is off
  assign next_pwm_trigger[0] = pin_f_i[`SPFS_PF_RX_A];
  assign next_pwm_trigger[1] = pin_f_i[`SPFS_PF_TX_A] &
    ~ser_tx_en_i[0];
  assign next_pwm_trigger[2] = pin_f_i[`SPFS_PF_RX_B];
  assign next_pwm_trigger[3] = pin_f_i[`SPFS_PF_TX_B] &
    ~ser_tx_en_i[1];
  assign next_ext_irq = pin_e_i[3:0] & irq_en_i;
  assign next_converter_trigger = pin_f_i[`SPFS_PF_WAVE_A] &
    adc_ext_trig_sel_i;

  // ==========================================================
  // Output registers
  // All outputs registered; pins released during reset
  always @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_b_o <= `SPFS_RST_STROBE;
      pin_e_o <= `SPFS_RST_PORT;
      pin_f_o <= `SPFS_RST_PORT;
      pin_b_oe_o <= `SPFS_RST_PORT;
      pin_e_oe_o <= `SPFS_RST_PORT;
      pin_f_oe_o <= `SPFS_RST_PORT;
      port_b_in_o <= `SPFS_RST_PORT;
      port_e_in_o <= `SPFS_RST_PORT;
      port_f_in_o <= `SPFS_RST_PORT;
      dma_request_o <= 3'h0;
      ser_clk_o <= 3'h0;
      ser_rx_o <= 3'h0;
      pwm_trigger_o <= 4'h0;
      ext_irq_o <= 4'h0;
      converter_trigger_o <= 1'b0;
      analog_inputs_en_o <= 4'h0;
    end
    else
    begin
      pin_b_o <= next_out[PORT_W-1:0];
      pin_e_o <= next_out[2*PORT_W-1:PORT_W];
      pin_f_o <= next_out[3*PORT_W-1:2*PORT_W];
      pin_b_oe_o <= next_oe[PORT_W-1:0];
      pin_e_oe_o <= next_oe[2*PORT_W-1:PORT_W];
      pin_f_oe_o <= next_oe[3*PORT_W-1:2*PORT_W];
      port_b_in_o <= pin_b_i;
      port_e_in_o <= pin_e_i;
      port_f_in_o <= pin_f_i;
      dma_request_o <= next_dma_request;
      ser_clk_o <= next_ser_clk;
      ser_rx_o <= {pin_f_i[`SPFS_PF_RX_C], pin_f_i[`SPFS_PF_RX_B],
        pin_f_i[`SPFS_PF_RX_A]};
      pwm_trigger_o <= next_pwm_trigger;
      ext_irq_o <= next_ext_irq;
      converter_trigger_o <= next_converter_trigger;
      analog_inputs_en_o <= analog_input_control_i;
    end
  end

endmodule

// ==== spfs_defs.vh ====
// Constants for the shared pin function select block: pin positions
// inside the three 8-bit ports and reset values of the pin registers.
// Assumes the includer uses these as bit indices of 8-bit port vectors.
//
// How it works
// - Peripheral output beats port output on pin
// - 16-bit two-strobe: low strobe even lane, high odd
// - 16-bit two-strobe mode: high strobe only odd lane
// - 16-bit one-strobe mode: high pin/write pin lane enables
// - DMA request sampled only when externally triggered
// - DMA acknowledge driven only when enabled
// - Serial clock driven only when output enabled
// - Serial data driven only when enabled
// - PWM wave driven only when output enabled
// - Interrupt pin sampled while interrupt enabled
// - Analog use only when control selects it
// - Converter trigger sampled only when selected
`ifndef SPFS_DEFS_VH
`define SPFS_DEFS_VH

// ==========================================================
// Port B: DRAM bank pins, DMA channel c request/acknowledge
`define SPFS_PB_ROW_A 0
`define SPFS_PB_COL_LOW_A 1
`define SPFS_PB_COL_HIGH_A 2
`define SPFS_PB_WRITE_A 3
`define SPFS_PB_ROW_B 4
`define SPFS_PB_COL_LOW_B 5
`define SPFS_PB_COL_HIGH_B 6
`define SPFS_PB_WRITE_B 7

// ==========================================================
// Port E: interrupts, serial clocks b/c, DMA channels a/b
`define SPFS_PE_IRQ_A 0
`define SPFS_PE_IRQ_B 1
`define SPFS_PE_IRQ_C 2
`define SPFS_PE_IRQ_D 3
`define SPFS_PE_DREQ_A 4
`define SPFS_PE_DREQ_B 5
`define SPFS_PE_DACK_A 6
`define SPFS_PE_DACK_B 7

// ==========================================================
// Port F: serial channels, PWM waves and triggers
`define SPFS_PF_RX_A 0
`define SPFS_PF_TX_A 1
`define SPFS_PF_SCLK_A 2
`define SPFS_PF_RX_B 3
`define SPFS_PF_TX_B 4
`define SPFS_PF_RX_C 5
`define SPFS_PF_TX_C 6
`define SPFS_PF_WAVE_A 7

// ==========================================================
// Reset values
`define SPFS_RST_PORT 8'h00
`define SPFS_RST_STROBE 8'hFF

`endif

// ==== spfs_dram_route.v ====
// One DRAM bank's strobe role router.
// Assumes active-low strobes from the memory controller, synchronous
// to the system clock; output is combinational, registered by the top.
`timescale 1ns/100ps

module spfs_dram_route
(
  input wire bus16_i,
  input wire one_col_i,
  input wire addr0_i,
  input wire row_n_i,
  input wire col_n_i,
  input wire write_n_i,
  output reg row_n_o,
  output reg col_low_n_o,
  output reg col_high_n_o,
  output reg write_n_o
);

  // ==========================================================
  // Strobe role selection
  // Role of each pin by bus width and strobe mode
  always @*
  begin
    row_n_o = row_n_i;
    if (!bus16_i)
    begin
      // Same column strobe on both pins, single write
      col_low_n_o = col_n_i;
      col_high_n_o = col_n_i;
      write_n_o = write_n_i;
    end
    else if (!one_col_i)
    begin
      // Even lane on low pin, odd lane on high pin
      col_low_n_o = col_n_i | addr0_i;
      col_high_n_o = col_n_i | ~addr0_i;
      write_n_o = write_n_i;
    end
    else
    begin
      // Single column strobe, two lane write enables
      col_low_n_o = col_n_i;
      col_high_n_o = write_n_i | addr0_i;
      write_n_o = write_n_i | ~addr0_i;
    end
  end

endmodule

// ==== spfs_top_props.sv ====
// Checker for the shared pin function select top.
// Assumes binding to spfs_top; every output lags its cause by 1 edge.
`timescale 1ns/100ps

module spfs_top_props #(
  parameter PORT_W = 8
)
(
  input wire clock_i,
  input wire rst_i,
  input wire [PORT_W-1:0] port_e_out_i,
  input wire [PORT_W-1:0] port_e_dir_i,
  input wire [PORT_W-1:0] pin_e_i,
  input wire [PORT_W-1:0] pin_f_i,
  input wire [PORT_W-1:0] pin_b_o,
  input wire [PORT_W-1:0] pin_e_o,
  input wire [PORT_W-1:0] pin_f_o,
  input wire [PORT_W-1:0] pin_e_oe_o,
  input wire [PORT_W-1:0] pin_f_oe_o,
  input wire [1:0] dram_pins_en_i,
  input wire dram_bus16_i,
  input wire dram_one_col_i,
  input wire dram_addr0_i,
  input wire [1:0] dram_col_n_i,
  input wire [1:0] dram_write_n_i,
  input wire [2:0] dma_ext_sel_i,
  input wire [2:0] dma_ack_en_i,
  input wire [2:0] dma_ack_i,
  input wire [2:0] dma_request_o,
  input wire [2:0] ser_clk_oe_i,
  input wire [2:0] ser_clk_i,
  input wire [2:0] ser_clk_o,
  input wire [2:0] ser_tx_en_i,
  input wire [2:0] ser_tx_i,
  input wire [3:0] pwm_out_en_i,
  input wire [3:0] pwm_wave_i,
  input wire [3:0] irq_en_i,
  input wire [3:0] ext_irq_o,
  input wire adc_ext_trig_sel_i,
  input wire converter_trigger_o,
  input wire [3:0] analog_input_control_i,
  input wire [3:0] analog_inputs_en_o
);
  // ==========================================================
  // Pin ownership
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_dack_drive: assert property (
    dma_ack_en_i[0] |=> pin_e_oe_o[6] && pin_e_o[6] == $past(dma_ack_i[0]))
    else $error("ack pin not driven by channel");
  chk_dack_fallback: assert property (
    !dma_ack_en_i[1] |=> pin_e_oe_o[7] == $past(port_e_dir_i[7])
      && pin_e_o[7] == $past(port_e_out_i[7]))
    else $error("ack pin not returned to port");
  chk_sclk_drive: assert property (
    ser_clk_oe_i[0] |=> pin_f_oe_o[2] && !ser_clk_o[0]
      && pin_f_o[2] == $past(ser_clk_i[0]))
    else $error("serial clock pin wrong");
  chk_tx_drive: assert property (
    ser_tx_en_i[2] |=> pin_f_oe_o[6] && pin_f_o[6] == $past(ser_tx_i[2]))
    else $error("tx pin not driven by channel");
  chk_wave_drive: assert property (
    pwm_out_en_i[0] |=> pin_f_oe_o[7] && pin_f_o[7] == $past(pwm_wave_i[0]))
    else $error("wave pin not driven by timer");
  // ==========================================================
  // Input gating
  chk_dreq_gate: assert property (
    1 |=> dma_request_o[1:0] == $past(dma_ext_sel_i[1:0] & pin_e_i[5:4]))
    else $error("request gating wrong");
  chk_irq_gate: assert property (
    1 |=> ext_irq_o == $past(irq_en_i & pin_e_i[3:0]))
    else $error("interrupt gating wrong");
  chk_analog_sel: assert property (
    1 |=> analog_inputs_en_o == $past(analog_input_control_i))
    else $error("analog select wrong");
  chk_conv_trig: assert property (
    1 |=> converter_trigger_o == $past(adc_ext_trig_sel_i & pin_f_i[7]))
    else $error("converter trigger gating wrong");
  // ==========================================================
  // DRAM strobe roles
  chk_two_strobe: assert property (
    dram_pins_en_i[0] && dram_bus16_i && !dram_one_col_i |=> pin_b_o[2:1]
      == $past({dram_col_n_i[0] | ~dram_addr0_i, dram_col_n_i[0] | dram_addr0_i}))
    else $error("two strobe lanes wrong");
  chk_one_strobe: assert property (
    dram_pins_en_i[1] && dram_bus16_i && dram_one_col_i |=> pin_b_o[7:5]
      == $past({dram_write_n_i[1] | ~dram_addr0_i,
      dram_write_n_i[1] | dram_addr0_i, dram_col_n_i[1]}))
    else $error("write lane roles wrong");
  chk_byte_mode: assert property (
    dram_pins_en_i[0] && !dram_bus16_i |=> pin_b_o[3:1]
      == $past({dram_write_n_i[0], {2{dram_col_n_i[0]}}}))
    else $error("byte mode strobes wrong");
endmodule

bind spfs_top spfs_top_props #(.PORT_W(PORT_W)) spfs_top_props_i (
  .clock_i, .rst_i, .port_e_out_i, .port_e_dir_i, .pin_e_i, .pin_f_i,
  .pin_b_o, .pin_e_o, .pin_f_o, .pin_e_oe_o, .pin_f_oe_o, .dram_pins_en_i,
  .dram_bus16_i, .dram_one_col_i, .dram_addr0_i, .dram_col_n_i,
  .dram_write_n_i, .dma_ext_sel_i, .dma_ack_en_i, .dma_ack_i, .dma_request_o,
  .ser_clk_oe_i, .ser_clk_i, .ser_clk_o, .ser_tx_en_i, .ser_tx_i,
  .pwm_out_en_i, .pwm_wave_i, .irq_en_i, .ext_irq_o, .adc_ext_trig_sel_i,
  .converter_trigger_o, .analog_input_control_i, .analog_inputs_en_o);

// ==== spfs_board.sv ====
// Board model: resolves each shared pad from device and board drivers.
// Assumes the bench supplies the board-side levels of every pad.
`timescale 1ns/100ps

module spfs_board
(
  input wire [23:0] dev_i,
  input wire [23:0] dev_oe_i,
  input wire [23:0] ext_i,
  output wire [23:0] pad_o
);
  // ==========================================================
  // Pad resolution
  // Board drivers stand off wherever the device drives
  assign pad_o = (dev_i & dev_oe_i) | (ext_i & ~dev_oe_i);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the shared pin function select top.
// Assumes the board model closes the pad loop; inputs move at negedge.
`timescale 1ns/100ps

module testbench;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] port_b_out_i, port_b_dir_i, port_e_out_i, port_e_dir_i;
  logic [7:0] port_f_out_i, port_f_dir_i;
  logic [23:0] ext = 24'hFFFFFF;
  wire [7:0] port_b_in_o, port_e_in_o, port_f_in_o, pin_b_i, pin_e_i, pin_f_i;
  wire [7:0] pin_b_o, pin_e_o, pin_f_o, pin_b_oe_o, pin_e_oe_o, pin_f_oe_o;
  logic [1:0] dram_pins_en_i, dram_row_n_i, dram_col_n_i, dram_write_n_i;
  logic dram_bus16_i, dram_one_col_i, dram_addr0_i, adc_ext_trig_sel_i;
  logic [2:0] dma_ext_sel_i, dma_ack_en_i, dma_ack_i, ser_clk_oe_i;
  logic [2:0] ser_clk_i, ser_tx_en_i, ser_tx_i;
  wire [2:0] dma_request_o, ser_clk_o, ser_rx_o;
  logic [3:0] pwm_out_en_i, pwm_wave_i, irq_en_i, analog_input_control_i;
  wire [3:0] pwm_trigger_o, ext_irq_o, analog_inputs_en_o;
  wire converter_trigger_o;
  int n_fail = 0;
  int total_checks = 0;
  // Rows: bus16, one_col, addr0, col_n, write_n | write, col high, col low
  logic [7:0] rows [7] = '{8'h8E, 8'hAD, 8'hC4, 8'hE2, 8'h2C, 8'h53, 8'hB3};

  spfs_top spfs_top_i (.clock_i, .rst_i, .port_b_out_i, .port_b_dir_i,
    .port_e_out_i, .port_e_dir_i, .port_f_out_i, .port_f_dir_i, .port_b_in_o,
    .port_e_in_o, .port_f_in_o, .pin_b_i, .pin_e_i, .pin_f_i, .pin_b_o,
    .pin_e_o, .pin_f_o, .pin_b_oe_o, .pin_e_oe_o, .pin_f_oe_o,
    .dram_pins_en_i, .dram_bus16_i, .dram_one_col_i, .dram_addr0_i,
    .dram_row_n_i, .dram_col_n_i, .dram_write_n_i, .dma_ext_sel_i,
    .dma_ack_en_i, .dma_ack_i, .dma_request_o, .ser_clk_oe_i, .ser_clk_i,
    .ser_tx_en_i, .ser_tx_i, .ser_clk_o, .ser_rx_o, .pwm_out_en_i,
    .pwm_wave_i, .pwm_trigger_o, .irq_en_i, .ext_irq_o, .adc_ext_trig_sel_i,
    .converter_trigger_o, .analog_input_control_i, .analog_inputs_en_o);
  spfs_board spfs_board_i (.dev_i({pin_b_o, pin_e_o, pin_f_o}),
    .dev_oe_i({pin_b_oe_o, pin_e_oe_o, pin_f_oe_o}), .ext_i(ext),
    .pad_o({pin_b_i, pin_e_i, pin_f_i}));

  // ==========================================================
  // Clock, helpers
  always #5 clock_i = ~clock_i;
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Let two edges land so pad loop settles
  task automatic go();
    repeat (2) @(negedge clock_i);
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    {port_b_out_i, port_b_dir_i, port_e_out_i, port_e_dir_i, port_f_out_i,
      port_f_dir_i, dram_pins_en_i, dram_col_n_i, dram_write_n_i,
      dram_bus16_i, dram_one_col_i, dram_addr0_i, adc_ext_trig_sel_i,
      dma_ext_sel_i, dma_ack_en_i, dma_ack_i, ser_clk_oe_i, ser_clk_i,
      ser_tx_en_i, ser_tx_i, pwm_out_en_i, pwm_wave_i, irq_en_i,
      analog_input_control_i} = '0;
    dram_row_n_i = 2'h2;
    repeat (3) @(negedge clock_i);
    chk(pin_b_o, 8'hFF);
    chk(pin_b_oe_o, 8'h00);
    rst_i = 1'b0;
    // DRAM strobe roles, both banks
    dram_pins_en_i = 2'h3;
    foreach (rows[i])
    begin
      {dram_bus16_i, dram_one_col_i, dram_addr0_i} = rows[i][7:5];
      dram_col_n_i = {2{rows[i][4]}};
      dram_write_n_i = {2{rows[i][3]}};
      go();
      chk(pin_b_o, {rows[i][2:0], 1'b1, rows[i][2:0], 1'b0});
      chk(pin_b_oe_o, 8'hFF);
    end
    // Peripherals claim pins against port drive
    dram_pins_en_i = 2'h0;
    {port_b_dir_i, port_e_dir_i, port_f_dir_i} = {3{8'hFF}};
    {dma_ack_en_i, dma_ack_i, ser_clk_oe_i, ser_clk_i} = 12'hFFF;
    {ser_tx_en_i, ser_tx_i, pwm_out_en_i, pwm_wave_i} = 14'h3FF3;
    go();
    chk(pin_f_o, 8'hF6);
    chk(pin_e_o, 8'hCC);
    chk(pin_b_o, 8'h40);
    // Peripherals off: port owns every pin
    {dma_ack_en_i, ser_clk_oe_i, ser_tx_en_i, pwm_out_en_i} = '0;
    {port_b_out_i, port_e_out_i, port_f_out_i} = {3{8'hA5}};
    go();
    chk(pin_b_o, 8'hA5);
    chk(pin_e_o, 8'hA5);
    chk(pin_f_o, 8'hA5);
    chk(pin_f_oe_o & port_f_in_o, 8'hA5);
    // Read-back of the pads that the ports now drive
    chk(port_b_in_o, 8'hA5);
    chk(port_e_in_o, 8'hA5);
    chk(8'(ser_rx_o), 8'h05);
    // Input gating, pads high from board
    {port_b_dir_i, port_e_dir_i, port_f_dir_i} = '0;
    {dma_ext_sel_i, irq_en_i, adc_ext_trig_sel_i} = 8'hB5;
    analog_input_control_i = 4'h9;
    go();
    chk({dma_request_o, ext_irq_o, converter_trigger_o}, 8'hB5);
    chk(8'(analog_inputs_en_o), 8'h09);
    chk(8'({ser_clk_o, pwm_trigger_o}), 8'h7F);
    {dma_ext_sel_i, irq_en_i, adc_ext_trig_sel_i} = 8'h4A;
    analog_input_control_i = 4'h6;
    {ser_clk_oe_i, ser_tx_en_i} = 6'h09;
    go();
    chk({dma_request_o, ext_irq_o, converter_trigger_o}, 8'h4A);
    chk(8'(analog_inputs_en_o), 8'h06);
    chk(8'({ser_clk_o, pwm_trigger_o}), 8'h6D);
    chk(pin_f_oe_o, 8'h06);
    chk(pin_e_oe_o, 8'h00);
    // Second reset in mid-run
    rst_i = 1'b1;
    @(negedge clock_i);
    chk(pin_b_o & ~pin_f_oe_o, 8'hFF);
    chk({dma_request_o, ext_irq_o, converter_trigger_o}, 8'h00);
    chk(pin_e_oe_o | pin_b_oe_o, 8'h00);
    rst_i = 1'b0;
    // First two edges after release: held inputs reloaded
    @(negedge clock_i);
    chk(pin_b_o, 8'hA5);
    chk(pin_f_oe_o, 8'h06);
    chk({dma_request_o, ext_irq_o, converter_trigger_o}, 8'h4A);
    @(negedge clock_i);
    chk(8'({ser_clk_o, pwm_trigger_o}), 8'h6D);
    tally_and_finish();
  end
endmodule
